// File: design/sync_rx_pkg.sv
// constants and types shared by the synchronous serial receiver
package sync_rx_pkg;

    // *******************************************************
    // register byte offsets on the bus
    // *******************************************************
    localparam logic [7:0] OFS_RCV_STATUS = 8'h00;
    localparam logic [7:0] OFS_XMT_STATUS = 8'h04;
    localparam logic [7:0] OFS_RX_CHAR = 8'h08;
    localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ENABLES = 8'h10;
    localparam logic [7:0] OFS_BAUD_DIV = 8'h14;

    // *******************************************************
    // field positions
    // *******************************************************
    localparam int RS_SERIAL_PORT_ENABLE = 7;
    localparam int RS_RX9 = 6;
    localparam int RS_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RS_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RS_ADDRESS_DETECT_ENABLE = 3;
    localparam int RS_OVERRUN_ERROR_FLAG = 1;
    localparam int RS_NINTH_RECEIVED_BIT = 0;
    localparam int TS_CLOCK_SOURCE_MASTER = 7;
    localparam int TS_TX9 = 6;
    localparam int TS_TXEN = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int TS_TRMT = 1;
    localparam int TS_TX9D = 0;
    localparam int PF_RX_FLAG = 5;
    localparam int PE_RX_IRQ_EN = 5;

    // *******************************************************
    // reset values and sizes
    // *******************************************************
    localparam logic [7:0] RCV_STATUS_RST = 8'h00;
    localparam logic [7:0] XMT_STATUS_RST = 8'h02;
    localparam logic [7:0] IRQ_ENABLES_RST = 8'h00;
    localparam logic [7:0] BAUD_DIV_RST = 8'h00;
    localparam int FIFO_DEPTH = 2;
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;

    typedef struct packed {
        logic ninth;
        logic [7:0] low;
    } rx_char_t;

endpackage

// File: design/sync_serial_receiver.sv
// receive path of a half-duplex synchronous serial port with apb registers
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - master receive keeps the data line driver off
// - master reception starts when single or continuous receive enable is set, slave reception only on continuous
// - single receive makes one character of clocks, then clears itself
// - continuous receive keeps clocking characters until cleared or until overrun sets
// - clearing continuous receive mid character with single receive clear stops clock, drops partial
// - both enables set: single clears after first character, continuous goes on
// - data sampled on trailing clock edge into the shift register
// - full character sets receive flag and enters two-deep fifo
// - received character register shows low eight bits of oldest entry
// - receive flag stays set while the fifo holds any character
// - slave mode turns clock driver off and shifts on external clock
// - data changes on leading edge, one bit per clock cycle
// - third character with full fifo sets overrun, keeps stored two
// - during overrun fifo stays readable, no new characters accepted
// - overrun clears by data read in single mode, continuous clear otherwise
// - clearing port enable resets the unit and its overrun
// - nine-bit mode shifts nine bits, ninth bit of oldest entry visible
// - receive flag with its enable set raises the interrupt request
// - master drives the shift clock, one cycle per data bit
module sync_serial_receiver (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic data_line_pin_in,
    output logic data_line_pin_out,
    output logic data_line_pin_oe_n_out,
    input wire logic clock_line_pin_in,
    output logic clock_line_pin_out,
    output logic clock_line_pin_oe_n_out,
    output logic irq_out
);
    import sync_rx_pkg::*;

    // *******************************************************
    // helpers
    // *******************************************************
    function automatic logic [3:0] char_bits(input logic nine);
        char_bits = nine ? BITS_LONG : BITS_SHORT;
    endfunction

    function automatic logic [9:0] half_period(input logic [7:0] div, input logic fast);
        half_period = fast ? {2'h0, div} : {1'h0, div, 1'h1};
    endfunction

    // *******************************************************
    // state declarations
    // *******************************************************
    logic serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q;
    logic clock_source_master_q, tx9_q, txen_q, sync_q, high_speed_baud_select_q, tx9d_q;
    logic rx_irq_en_q;
    logic [7:0] baud_q;
    logic overrun_error_flag_q, overrun_error_flag_single_q;
    logic data_s1_q, data_s2_q, clk_s1_q, clk_s2_q, clk_s3_q;
    logic [9:0] half_cnt_q;
    logic mclk_q;
    logic [3:0] bit_cnt_q;
    rx_char_t shift_q;
    rx_char_t fifo_q [FIFO_DEPTH];
    logic rd_ptr_q, wr_ptr_q;
    logic [1:0] count_q;
    logic flag_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic irq_q, clk_oe_n_q;

    // *******************************************************
    // bus decode
    // *******************************************************
    logic access_w, done_acc, wr_w, rd_w;
    logic hit_w;
    logic wr_rcv, wr_xmt, wr_ie, wr_baud, pop_w;
    assign access_w = psel_in && penable_in && !pready_q;
    assign done_acc = psel_in && penable_in && pready_q;
    assign wr_w = done_acc && pwrite_in;
    assign rd_w = done_acc && !pwrite_in;
    assign hit_w = (paddr_in == OFS_RCV_STATUS) || (paddr_in == OFS_XMT_STATUS) ||
                   (paddr_in == OFS_RX_CHAR) || (paddr_in == OFS_PERIPH_FLAGS) ||
                   (paddr_in == OFS_IRQ_ENABLES) || (paddr_in == OFS_BAUD_DIV);
    assign wr_rcv = wr_w && (paddr_in == OFS_RCV_STATUS);
    assign wr_xmt = wr_w && (paddr_in == OFS_XMT_STATUS);
    assign wr_ie = wr_w && (paddr_in == OFS_IRQ_ENABLES);
    assign wr_baud = wr_w && (paddr_in == OFS_BAUD_DIV);
    assign pop_w = rd_w && (paddr_in == OFS_RX_CHAR) && (count_q != 2'h0);

    // *******************************************************
    // receive control
    // *******************************************************
    logic master_w, slave_w, m_run, s_run, rx_run;
    logic m_fall, s_fall, sample_w, done_w, push_w, over_w;
    rx_char_t char_w;
    assign master_w = serial_port_enable_q && sync_q && clock_source_master_q;
    assign slave_w = serial_port_enable_q && sync_q && !clock_source_master_q;
    assign m_run = master_w && (single_receive_enable_q || continuous_receive_enable_q) && !overrun_error_flag_q;
    assign s_run = slave_w && continuous_receive_enable_q && !overrun_error_flag_q;
    assign rx_run = m_run || s_run;
    assign m_fall = m_run && (half_cnt_q == 10'h000) && mclk_q;
    assign s_fall = clk_s3_q && !clk_s2_q;
    assign sample_w = m_run ? m_fall : (s_run && s_fall);
    assign done_w = sample_w && (bit_cnt_q == char_bits(rx9_q) - 4'h1);
    assign push_w = done_w && ((count_q != 2'(FIFO_DEPTH)) || pop_w);
    assign over_w = done_w && (count_q == 2'(FIFO_DEPTH)) && !pop_w;

    always_comb
    begin
        char_w = shift_q;
        if (bit_cnt_q == BITS_LONG - 4'h1)
        begin
            char_w.ninth = data_s2_q;
        end
        else
        begin
            char_w.low[bit_cnt_q[2:0]] = data_s2_q;
        end
        if (!rx9_q)
        begin
            char_w.ninth = 1'h0;
        end
    end

    // *******************************************************
    // pin synchronisers
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            data_s1_q <= 1'h0;
            data_s2_q <= 1'h0;
            clk_s1_q <= 1'h0;
            clk_s2_q <= 1'h0;
            clk_s3_q <= 1'h0;
        end
        else
        begin
            data_s1_q <= data_line_pin_in;
            data_s2_q <= data_s1_q;
            clk_s1_q <= clock_line_pin_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
        end
    end

    // *******************************************************
    // configuration registers
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            serial_port_enable_q <= RCV_STATUS_RST[RS_SERIAL_PORT_ENABLE];
            rx9_q <= RCV_STATUS_RST[RS_RX9];
            continuous_receive_enable_q <= RCV_STATUS_RST[RS_CONTINUOUS_RECEIVE_ENABLE];
            address_detect_enable_q <= RCV_STATUS_RST[RS_ADDRESS_DETECT_ENABLE];
            clock_source_master_q <= XMT_STATUS_RST[TS_CLOCK_SOURCE_MASTER];
            tx9_q <= XMT_STATUS_RST[TS_TX9];
            txen_q <= XMT_STATUS_RST[TS_TXEN];
            sync_q <= XMT_STATUS_RST[TS_SYNC];
            high_speed_baud_select_q <= XMT_STATUS_RST[TS_HIGH_SPEED_BAUD_SELECT];
            tx9d_q <= XMT_STATUS_RST[TS_TX9D];
            rx_irq_en_q <= IRQ_ENABLES_RST[PE_RX_IRQ_EN];
            baud_q <= BAUD_DIV_RST;
        end
        else
        begin
            if (wr_rcv)
            begin
                serial_port_enable_q <= pwdata_in[RS_SERIAL_PORT_ENABLE];
                rx9_q <= pwdata_in[RS_RX9];
                continuous_receive_enable_q <= pwdata_in[RS_CONTINUOUS_RECEIVE_ENABLE];
                address_detect_enable_q <= pwdata_in[RS_ADDRESS_DETECT_ENABLE];
            end
            if (wr_xmt)
            begin
                clock_source_master_q <= pwdata_in[TS_CLOCK_SOURCE_MASTER];
                tx9_q <= pwdata_in[TS_TX9];
                txen_q <= pwdata_in[TS_TXEN];
                sync_q <= pwdata_in[TS_SYNC];
                high_speed_baud_select_q <= pwdata_in[TS_HIGH_SPEED_BAUD_SELECT];
                tx9d_q <= pwdata_in[TS_TX9D];
            end
            if (wr_ie)
            begin
                rx_irq_en_q <= pwdata_in[PE_RX_IRQ_EN];
            end
            if (wr_baud)
            begin
                baud_q <= pwdata_in[7:0];
            end
        end
    end

    // single receive: software write wins over the self clear
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            single_receive_enable_q <= RCV_STATUS_RST[RS_SINGLE_RECEIVE_ENABLE];
        end
        else if (wr_rcv)
        begin
            single_receive_enable_q <= pwdata_in[RS_SINGLE_RECEIVE_ENABLE];
        end
        else if (done_w && m_run)
        begin
            single_receive_enable_q <= 1'h0;
        end
    end

    // *******************************************************
    // master shift clock generator
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            half_cnt_q <= 10'h000;
            mclk_q <= 1'h0;
        end
        else if (!m_run)
        begin
            half_cnt_q <= half_period(baud_q, high_speed_baud_select_q);
            mclk_q <= 1'h0;
        end
        else if (half_cnt_q == 10'h000)
        begin
            half_cnt_q <= half_period(baud_q, high_speed_baud_select_q);
            mclk_q <= !mclk_q;
        end
        else
        begin
            half_cnt_q <= half_cnt_q - 10'h001;
        end
    end

    // *******************************************************
    // shift register
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            bit_cnt_q <= 4'h0;
            shift_q <= '0;
        end
        else if (!rx_run)
        begin
            bit_cnt_q <= 4'h0;
            shift_q <= '0;
        end
        else if (done_w)
        begin
            bit_cnt_q <= 4'h0;
            shift_q <= '0;
        end
        else if (sample_w)
        begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q <= char_w;
        end
    end

    // *******************************************************
    // receive fifo
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rd_ptr_q <= 1'h0;
            wr_ptr_q <= 1'h0;
            count_q <= 2'h0;
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
        end
        else if (!serial_port_enable_q)
        begin
            rd_ptr_q <= 1'h0;
            wr_ptr_q <= 1'h0;
            count_q <= 2'h0;
        end
        else
        begin
            if (push_w)
            begin
                fifo_q[wr_ptr_q] <= char_w;
                wr_ptr_q <= !wr_ptr_q;
            end
            if (pop_w)
            begin
                rd_ptr_q <= !rd_ptr_q;
            end
            if (push_w && !pop_w)
            begin
                count_q <= count_q + 2'h1;
            end
            else if (pop_w && !push_w)
            begin
                count_q <= count_q - 2'h1;
            end
        end
    end

    // *******************************************************
    // overrun
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            overrun_error_flag_q <= 1'h0;
            overrun_error_flag_single_q <= 1'h0;
        end
        else if (!serial_port_enable_q)
        begin
            overrun_error_flag_q <= 1'h0;
        end
        else if (over_w)
        begin
            overrun_error_flag_q <= 1'h1;
            overrun_error_flag_single_q <= single_receive_enable_q && !continuous_receive_enable_q;
        end
        else if (overrun_error_flag_q && overrun_error_flag_single_q && rd_w && (paddr_in == OFS_RX_CHAR))
        begin
            overrun_error_flag_q <= 1'h0;
        end
        else if (overrun_error_flag_q && !overrun_error_flag_single_q && !continuous_receive_enable_q)
        begin
            overrun_error_flag_q <= 1'h0;
        end
    end

    // *******************************************************
    // flag, interrupt and pin drivers
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            flag_q <= 1'h0;
            irq_q <= 1'h0;
            clk_oe_n_q <= 1'h1;
        end
        else
        begin
            flag_q <= (count_q != 2'h0);
            irq_q <= (count_q != 2'h0) && rx_irq_en_q;
            clk_oe_n_q <= !master_w;
        end
    end

    // *******************************************************
    // apb answer
    // *******************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= access_w;
            pslverr_q <= access_w && !hit_w;
            if (access_w && !pwrite_in)
            begin
                prdata_q <= 32'h0000_0000;
                case (paddr_in)
                    OFS_RCV_STATUS:
                    begin
                        prdata_q[RS_SERIAL_PORT_ENABLE] <= serial_port_enable_q;
                        prdata_q[RS_RX9] <= rx9_q;
                        prdata_q[RS_SINGLE_RECEIVE_ENABLE] <= single_receive_enable_q;
                        prdata_q[RS_CONTINUOUS_RECEIVE_ENABLE] <= continuous_receive_enable_q;
                        prdata_q[RS_ADDRESS_DETECT_ENABLE] <= address_detect_enable_q;
                        prdata_q[RS_OVERRUN_ERROR_FLAG] <= overrun_error_flag_q;
                        prdata_q[RS_NINTH_RECEIVED_BIT] <= fifo_q[rd_ptr_q].ninth;
                    end
                    OFS_XMT_STATUS:
                    begin
                        prdata_q[TS_CLOCK_SOURCE_MASTER] <= clock_source_master_q;
                        prdata_q[TS_TX9] <= tx9_q;
                        prdata_q[TS_TXEN] <= txen_q;
                        prdata_q[TS_SYNC] <= sync_q;
                        prdata_q[TS_HIGH_SPEED_BAUD_SELECT] <= high_speed_baud_select_q;
                        prdata_q[TS_TRMT] <= 1'h1;
                        prdata_q[TS_TX9D] <= tx9d_q;
                    end
                    OFS_RX_CHAR: prdata_q[7:0] <= fifo_q[rd_ptr_q].low;
                    OFS_PERIPH_FLAGS: prdata_q[PF_RX_FLAG] <= (count_q != 2'h0);
                    OFS_IRQ_ENABLES: prdata_q[PE_RX_IRQ_EN] <= rx_irq_en_q;
                    OFS_BAUD_DIV: prdata_q[7:0] <= baud_q;
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign data_line_pin_out = 1'h0;
    assign data_line_pin_oe_n_out = 1'h1;
    assign clock_line_pin_out = mclk_q;
    assign clock_line_pin_oe_n_out = clk_oe_n_q;
    assign irq_out = irq_q;

    // *******************************************************
    // assertions
    // *******************************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_data_driver_off: assert property (data_line_pin_oe_n_out)
        else $error("data line driver enabled");
    a_single_autoclear: assert property (done_w && m_run && !wr_rcv |=> !single_receive_enable_q)
        else $error("single receive not cleared after character");
    a_continuous_receive_enable_stop: assert property (master_w && !single_receive_enable_q && $fell(continuous_receive_enable_q) && !overrun_error_flag_q
        |=> !mclk_q && bit_cnt_q == 4'h0)
        else $error("clock or partial character kept after continuous clear");
    a_overrun_set: assert property (over_w && serial_port_enable_q |=> overrun_error_flag_q && count_q == 2'h2)
        else $error("overrun not flagged or fifo disturbed");
    a_overrun_block: assert property (overrun_error_flag_q |-> !push_w && bit_cnt_q == 4'h0)
        else $error("character accepted during overrun");
    a_flag_tracks: assert property (##1 flag_q == ($past(count_q) != 2'h0))
        else $error("receive flag does not follow fifo");
    a_serial_port_enable_reset: assert property (!serial_port_enable_q |=> count_q == 2'h0 && !overrun_error_flag_q)
        else $error("port disable did not reset unit");
    a_clk_driver: assert property (##1 clock_line_pin_oe_n_out == !$past(master_w))
        else $error("clock driver state wrong for mode");
    a_irq_raise: assert property (flag_q && rx_irq_en_q && $stable(rx_irq_en_q) |-> irq_q)
        else $error("interrupt missing");
    a_pop_advance: assert property (serial_port_enable_q && pop_w && !push_w
        |=> count_q == $past(count_q) - 2'h1)
        else $error("read did not advance fifo");

endmodule // sync_serial_receiver
`default_nettype wire

// File: bench/sync_peer.sv
// far-side peer model of the synchronous receive link
`timescale 1ns/1ps
`default_nettype none
module sync_peer (
    input wire logic clk_line_in,
    output logic data_out,
    output logic clk_out,
    output logic clk_oe_n_out
);
    logic [8:0] pat [0:3];
    int nb = 8;
    int rc = 0;
    initial
    begin
        data_out = 1'b0;
        clk_out = 1'b0;
        clk_oe_n_out = 1'b1;
    end
    // next bit on the leading edge of the device clock
    always @(posedge clk_line_in)
    begin
        if (clk_oe_n_out)
        begin
            data_out <= pat[rc / nb][rc % nb];
            rc <= rc + 1;
        end
    end
    // line released after the last bit: show the inverse
    always @(negedge clk_line_in)
    begin
        if (clk_oe_n_out && rc % nb == 0)
            data_out <= ~data_out;
    end
    // peer as master: nb clocks only, idle low between frames
    task automatic send(input logic [8:0] ch);
        clk_oe_n_out = 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            clk_out = 1'b1;
            data_out = ch[i];
            #400;
            clk_out = 1'b0;
            #400;
        end
        data_out = ~data_out;
        clk_oe_n_out = 1'b1;
    endtask
endmodule // sync_peer
`default_nettype wire

// File: bench/sync_serial_receiver_bench.sv
// self-checking testbench of the synchronous serial receiver
`timescale 1ns/1ps
`default_nettype none
module sync_serial_receiver_bench;
    import sync_rx_pkg::*;
    logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic data_drv, data_oe_n, peer_data, clk_pin, clk_oe_n, peer_clk, peer_oe_n, prev_clk;
    wire data_line;
    wire clk_line;
    int failures = 0;
    int checks = 0;
    int rises = 0;
    int r0, n;
    assign data_line = !data_oe_n ? data_drv : peer_data;
    assign clk_line = !clk_oe_n ? clk_pin : (!peer_oe_n ? peer_clk : 1'b0);
    sync_serial_receiver sync_serial_receiver_i (
        .ref_clk_in(ref_clk),
        .reset_n_in(reset_n),
        .psel_in(psel),
        .penable_in(penable),
        .pwrite_in(pwrite),
        .paddr_in(paddr),
        .pwdata_in(pwdata),
        .prdata_out(prdata),
        .pready_out(pready),
        .pslverr_out(pslverr),
        .data_line_pin_in(data_line),
        .data_line_pin_out(data_drv),
        .data_line_pin_oe_n_out(data_oe_n),
        .clock_line_pin_in(clk_line),
        .clock_line_pin_out(clk_pin),
        .clock_line_pin_oe_n_out(clk_oe_n),
        .irq_out(irq)
    );
    sync_peer sync_peer_i (
        .clk_line_in(clk_line),
        .data_out(peer_data),
        .clk_out(peer_clk),
        .clk_oe_n_out(peer_oe_n)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // count rising edges of the master shift clock
    always @(posedge ref_clk)
    begin
        prev_clk <= clk_pin;
        if (clk_pin === 1'b1 && prev_clk === 1'b0)
            rises <= rises + 1;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // look mid cycle, then hold the request through the ready edge
        do
        begin
            @(negedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            failures++;
        rdata = prdata;
        err = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, e);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        apb(1'b0, a, 32'h0);
        while ((rdata & m) !== v && k++ < 300)
            apb(1'b0, a, 32'h0);
        chk(rdata & m, v);
    endtask
    task automatic end_of_test();
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(OFS_RCV_STATUS, 32'hfe, 32'h0);
        rd_chk(OFS_XMT_STATUS, 32'hff, {24'h0, XMT_STATUS_RST});
        rd_chk(OFS_PERIPH_FLAGS, 32'hff, 32'h0);
        rd_chk(8'h18, 32'hffffffff, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_single();
        sync_peer_i.nb = 8;
        sync_peer_i.rc = 0;
        sync_peer_i.pat[0] = 9'h0a5;
        wr(OFS_BAUD_DIV, 32'h3);
        wr(OFS_XMT_STATUS, 32'h94);
        wr(OFS_IRQ_ENABLES, 32'h20);
        r0 = rises;
        wr(OFS_RCV_STATUS, 32'ha0);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, data_oe_n}, 32'h1);
        chk({31'h0, clk_oe_n}, 32'h0);
        n = 0;
        while (clk_pin !== 1'b1 && n++ < 100)
            @(posedge ref_clk);
        n = 0;
        while (clk_pin === 1'b1 && n++ < 100)
            @(posedge ref_clk);
        chk(32'(n), 32'h4);
        poll(OFS_RCV_STATUS, 32'h20, 32'h0);
        chk(32'(rises - r0), 32'h8);
        rd_chk(OFS_PERIPH_FLAGS, 32'hff, 32'h20);
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFS_RX_CHAR, 32'hffffffff, 32'ha5);
        rd_chk(OFS_PERIPH_FLAGS, 32'hff, 32'h0);
    endtask
    task automatic t_overrun();
        sync_peer_i.nb = 9;
        sync_peer_i.rc = 0;
        sync_peer_i.pat[0] = 9'h1a1;
        sync_peer_i.pat[1] = 9'h0b2;
        sync_peer_i.pat[2] = 9'h1c3;
        sync_peer_i.pat[3] = 9'h0d4;
        r0 = rises;
        wr(OFS_RCV_STATUS, 32'hf0);
        poll(OFS_RCV_STATUS, 32'h02, 32'h02);
        repeat (100) @(posedge ref_clk);
        chk(32'(rises - r0), 32'd27);
        rd_chk(OFS_RCV_STATUS, 32'hff, 32'hd3);
        rd_chk(OFS_RX_CHAR, 32'hff, 32'ha1);
        rd_chk(OFS_RCV_STATUS, 32'hff, 32'hd2);
        rd_chk(OFS_RX_CHAR, 32'hff, 32'hb2);
        rd_chk(OFS_RCV_STATUS, 32'h02, 32'h02);
        wr(OFS_RCV_STATUS, 32'hc0);
        rd_chk(OFS_RCV_STATUS, 32'hfe, 32'hc0);
    endtask
    task automatic t_abort();
        sync_peer_i.nb = 8;
        sync_peer_i.rc = 0;
        r0 = rises;
        wr(OFS_RCV_STATUS, 32'h90);
        n = 0;
        while (rises - r0 < 3 && n++ < 200)
            @(posedge ref_clk);
        wr(OFS_RCV_STATUS, 32'h80);
        repeat (2) @(posedge ref_clk);
        r0 = rises;
        chk({31'h0, clk_pin}, 32'h0);
        repeat (100) @(posedge ref_clk);
        chk(32'(rises - r0), 32'h0);
        rd_chk(OFS_PERIPH_FLAGS, 32'hff, 32'h0);
    endtask
    task automatic t_single_ovr();
        sync_peer_i.rc = 0;
        sync_peer_i.pat[0] = 9'h011;
        sync_peer_i.pat[1] = 9'h022;
        sync_peer_i.pat[2] = 9'h033;
        repeat (3)
        begin
            wr(OFS_RCV_STATUS, 32'ha0);
            poll(OFS_RCV_STATUS, 32'h20, 32'h0);
        end
        rd_chk(OFS_RCV_STATUS, 32'hfe, 32'h82);
        rd_chk(OFS_RX_CHAR, 32'hff, 32'h11);
        rd_chk(OFS_RCV_STATUS, 32'h02, 32'h0);
        wr(OFS_RCV_STATUS, 32'h0);
        rd_chk(OFS_PERIPH_FLAGS, 32'hff, 32'h0);
    endtask
    task automatic t_slave();
        wr(OFS_XMT_STATUS, 32'h10);
        wr(OFS_RCV_STATUS, 32'h90);
        chk({31'h0, clk_oe_n}, 32'h1);
        sync_peer_i.nb = 8;
        sync_peer_i.send(9'h03c);
        poll(OFS_PERIPH_FLAGS, 32'h20, 32'h20);
        rd_chk(OFS_RX_CHAR, 32'hff, 32'h3c);
    endtask
    initial
    begin
        #2000000;
        failures++;
        end_of_test();
    end
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_single();
        t_overrun();
        t_abort();
        t_single_ovr();
        t_slave();
        end_of_test();
    end
endmodule // sync_serial_receiver_bench
`default_nettype wire
